// ===== logic/sfe_pkg.sv
// constants and types for the serial flash erase and program sequencer
package sfe_pkg;
  localparam int          ADDR_W        = 24;
  localparam int          BP_W          = 4;
  localparam int          CNT_W         = 6;
  localparam int          PAGE_BYTES    = 256;
  localparam int          SECTOR_LSB    = 12;
  localparam int          HALF_LSB      = 15;
  localparam int          BLOCK_LSB     = 16;
  localparam int          PAGE_LSB      = 8;
  localparam logic [5:0]  CNT_OPCODE    = 6'h08;
  localparam logic [5:0]  CNT_ADDR      = 6'h20;
  localparam logic [5:0]  CNT_DATA_END  = 6'h28;
  localparam logic [5:0]  CNT_DATA_WRAP = 6'h21;
  localparam logic [7:0]  RESET_BYTE    = 8'hFF;
  localparam logic [8:0]  BLOCK_COUNT   = 9'h100;
  localparam logic [3:0]  BP_NONE       = 4'h0;
  localparam logic [7:0]  OPC_UNLOCK    = 8'h06;
  localparam logic [7:0]  OPC_SECTOR    = 8'h20;
  localparam logic [7:0]  OPC_HALF      = 8'h52;
  localparam logic [7:0]  OPC_BLOCK     = 8'hD8;
  localparam logic [7:0]  OPC_CHIP      = 8'h60;
  localparam logic [7:0]  OPC_PAGE      = 8'h02;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SECTOR_ERASE_TIME_NS = 20000;
  localparam int          HALF_BLOCK_ERASE_TIME_NS = 40000;
  localparam int          BLOCK_ERASE_TIME_NS = 60000;
  localparam int          WHOLE_ERASE_TIME_NS = 200000;
  localparam int          PAGE_PROGRAM_TIME_NS = 5000;

  typedef enum logic [2:0] {
    SFE_OP_NONE,
    SFE_OP_SECTOR,
    SFE_OP_HALF,
    SFE_OP_BLOCK,
    SFE_OP_CHIP,
    SFE_OP_PAGE
  } sfe_op_t;

  typedef enum logic {
    SFE_IDLE,
    SFE_RUN
  } sfe_state_t;
endpackage

// ===== logic/sfe_sequencer.sv
// erase and program command sequencer: link shifter on the serial clock, self-timer on core_clk
`timescale 1ns/100ps
module sfe_sequencer #(
  parameter int             SECTOR_ERASE_TIME_NS     = sfe_pkg::SECTOR_ERASE_TIME_NS,
  parameter int             HALF_BLOCK_ERASE_TIME_NS = sfe_pkg::HALF_BLOCK_ERASE_TIME_NS,
  parameter int             BLOCK_ERASE_TIME_NS      = sfe_pkg::BLOCK_ERASE_TIME_NS,
  parameter int             WHOLE_ERASE_TIME_NS      = sfe_pkg::WHOLE_ERASE_TIME_NS,
  parameter int             PAGE_PROGRAM_TIME_NS     = sfe_pkg::PAGE_PROGRAM_TIME_NS
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         spi_sclk,
  input  wire logic                         spi_cs_n,
  input  wire logic                         spi_si,
  input  wire logic                         enh_enter,
  input  wire logic                         enh_exit,
  input  wire logic [sfe_pkg::BP_W-1:0]     block_protection_level,
  output logic                              write_latch_flag,
  output logic                              busy_in_cycle_flag,
  output logic                              enh_mode_active,
  output logic                              arr_op_start,
  output sfe_pkg::sfe_op_t                  arr_op,
  output logic [sfe_pkg::ADDR_W-1:0]        arr_addr,
  input  wire logic [7:0]                   arr_rd_idx,
  output logic [7:0]                        arr_rd_data,
  output logic                              arr_rd_valid
);
  import sfe_pkg::*;

  localparam logic [31:0] SECTOR_CYC =
    32'((SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] HALF_CYC =
    32'((HALF_BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] BLOCK_CYC =
    32'((BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] WHOLE_CYC =
    32'((WHOLE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] PAGE_CYC =
    32'((PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------- link domain (spi_sclk) ----------------
  typedef struct packed {
    logic [7:0]                 shreg;
    logic [7:0]                 opcode;
    logic [ADDR_W-1:0]          addr;
    logic [CNT_W-1:0]           last_cnt;
    logic                       frame_enh;
    logic                       enh;
    logic                       tok;
    logic [7:0]                 wptr;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0]      pmask;
    logic                       busy_s1;
    logic                       busy_s2;
  } sfe_link_t;

  sfe_link_t        lk_ff;
  sfe_link_t        nxt_lk;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [7:0]       byte_in;
  logic             fenh;
  logic             core_busy;

  // bit counter lives only inside a frame; chip select high clears it at once,
  // so the first edge of every frame is bit one even though sclk stops between frames
  always_comb begin
    byte_in = {lk_ff.shreg[6:0], spi_si};
    if (cnt_ff == CNT_DATA_END) begin
      nxt_cnt = CNT_DATA_WRAP;
    end else begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_comb begin
    nxt_lk          = lk_ff;
    nxt_lk.busy_s1  = core_busy;
    nxt_lk.busy_s2  = lk_ff.busy_s1;
    nxt_lk.shreg    = byte_in;
    nxt_lk.last_cnt = nxt_cnt;
    fenh            = (cnt_ff == '0) ? lk_ff.enh : lk_ff.frame_enh;
    if (cnt_ff == '0) begin
      nxt_lk.frame_enh = lk_ff.enh;
      nxt_lk.tok       = ~lk_ff.tok;
    end
    if (!fenh) begin
      if (nxt_cnt == CNT_OPCODE) begin
        nxt_lk.opcode = byte_in;
      end
      if (cnt_ff >= CNT_OPCODE && cnt_ff < CNT_ADDR) begin
        nxt_lk.addr = {lk_ff.addr[ADDR_W-2:0], spi_si};
      end
      if (lk_ff.opcode == OPC_PAGE && nxt_cnt == CNT_ADDR) begin
        nxt_lk.wptr  = byte_in;
        nxt_lk.pmask = '0;
      end
      // a second page program sent while busy stores no data bytes, but its last address byte still reloads wptr and clears pmask
      if (lk_ff.opcode == OPC_PAGE && nxt_cnt == CNT_DATA_END && !lk_ff.busy_s2) begin
        nxt_lk.pbuf[lk_ff.wptr]  = byte_in;
        nxt_lk.pmask[lk_ff.wptr] = 1'b1;
        nxt_lk.wptr              = lk_ff.wptr + 8'h01;
      end
    end else if (nxt_cnt == CNT_OPCODE && byte_in == RESET_BYTE) begin
      nxt_lk.enh = 1'b0;
    end
    if (enh_exit) begin
      nxt_lk.enh = 1'b0;
    end
    if (enh_enter) begin
      nxt_lk.enh = 1'b1;
    end
  end

  // rst clears this domain asynchronously because sclk may be stopped at reset
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  assign enh_mode_active = lk_ff.enh;

  // ---------------- core domain (core_clk) ----------------
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_prev;
    logic              tok_s1;
    logic              tok_s2;
    logic              tok_seen;
    logic              wlf;
    sfe_state_t        st;
    logic [31:0]       timer;
    logic              op_start;
    sfe_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        rd_data;
    logic              rd_valid;
  } sfe_core_t;

  sfe_core_t         cr_ff;
  sfe_core_t         nxt_cr;
  logic              frame_end;
  sfe_op_t           cmd_op;
  logic              shape_ok;
  logic              prot_hit;
  logic [ADDR_W-1:0] span_mask;
  logic [31:0]       cmd_cyc;

  function automatic logic is_protected(input logic [BP_W-1:0] lvl,
                                        input logic [ADDR_W-1:0] top);
    logic [8:0] prot_blocks;
    logic [8:0] base_blk;
    prot_blocks = '0;
    base_blk    = '0;
    if (lvl == BP_NONE) begin
      return 1'b0;
    end
    if (lvl > 4'h8) begin
      return 1'b1;
    end
    prot_blocks = 9'h001 << (lvl - 4'h1);
    base_blk    = BLOCK_COUNT - prot_blocks;
    return {1'b0, top[ADDR_W-1:BLOCK_LSB]} >= base_blk;
  endfunction

  // decode of the finished frame; link fields are quiet here because sclk
  // does not run while chip select is high
  always_comb begin
    cmd_op    = SFE_OP_NONE;
    shape_ok  = 1'b0;
    span_mask = '0;
    cmd_cyc   = PAGE_CYC;
    unique case (lk_ff.opcode)
      OPC_SECTOR: begin
        cmd_op    = SFE_OP_SECTOR;
        shape_ok  = (lk_ff.last_cnt == CNT_ADDR);
        span_mask = ADDR_W'((1 << SECTOR_LSB) - 1);
        cmd_cyc   = SECTOR_CYC;
      end
      OPC_HALF: begin
        cmd_op    = SFE_OP_HALF;
        shape_ok  = (lk_ff.last_cnt == CNT_ADDR);
        span_mask = ADDR_W'((1 << HALF_LSB) - 1);
        cmd_cyc   = HALF_CYC;
      end
      OPC_BLOCK: begin
        cmd_op    = SFE_OP_BLOCK;
        shape_ok  = (lk_ff.last_cnt == CNT_ADDR);
        span_mask = ADDR_W'((1 << BLOCK_LSB) - 1);
        cmd_cyc   = BLOCK_CYC;
      end
      OPC_CHIP: begin
        cmd_op    = SFE_OP_CHIP;
        shape_ok  = (lk_ff.last_cnt == CNT_OPCODE);
        span_mask = '1;
        cmd_cyc   = WHOLE_CYC;
      end
      OPC_PAGE: begin
        cmd_op    = SFE_OP_PAGE;
        shape_ok  = (lk_ff.last_cnt == CNT_DATA_END);
        span_mask = ADDR_W'((1 << PAGE_LSB) - 1);
        cmd_cyc   = PAGE_CYC;
      end
      default: begin
        cmd_op = SFE_OP_NONE;
      end
    endcase
    if (cmd_op == SFE_OP_CHIP) begin
      prot_hit = (block_protection_level != BP_NONE);
    end else begin
      prot_hit = is_protected(block_protection_level, lk_ff.addr | span_mask);
    end
  end

  assign frame_end = cr_ff.cs_s2 && !cr_ff.cs_prev && (cr_ff.tok_s2 != cr_ff.tok_seen);

  always_comb begin
    nxt_cr          = cr_ff;
    nxt_cr.cs_s1    = spi_cs_n;
    nxt_cr.cs_s2    = cr_ff.cs_s1;
    nxt_cr.cs_prev  = cr_ff.cs_s2;
    nxt_cr.tok_s1   = lk_ff.tok;
    nxt_cr.tok_s2   = cr_ff.tok_s1;
    nxt_cr.op_start = 1'b0;
    nxt_cr.rd_data  = lk_ff.pbuf[arr_rd_idx];
    nxt_cr.rd_valid = lk_ff.pmask[arr_rd_idx];
    if (frame_end) begin
      nxt_cr.tok_seen = cr_ff.tok_s2;
    end
    unique case (cr_ff.st)
      SFE_IDLE: begin
        // enhanced-mode frames belong to the read path, never to this decoder
        if (frame_end && !lk_ff.frame_enh) begin
          if (lk_ff.opcode == OPC_UNLOCK && lk_ff.last_cnt == CNT_OPCODE) begin
            nxt_cr.wlf = 1'b1;
          end else if (cmd_op != SFE_OP_NONE && shape_ok && cr_ff.wlf && !prot_hit) begin
            // start at the chip select rise; rejects fall through untouched
            nxt_cr.st       = SFE_RUN;
            nxt_cr.timer    = cmd_cyc - 32'h0000_0001;
            nxt_cr.op_start = 1'b1;
            nxt_cr.op       = cmd_op;
            nxt_cr.addr     = lk_ff.addr & ~span_mask;
          end
        end
      end
      SFE_RUN: begin
        if (cr_ff.timer == '0) begin
          nxt_cr.st  = SFE_IDLE;
          nxt_cr.wlf = 1'b0;
        end else begin
          nxt_cr.timer = cr_ff.timer - 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cr_ff       <= '0;
      cr_ff.cs_s1 <= 1'b1;
      cr_ff.cs_s2 <= 1'b1;
      cr_ff.cs_prev <= 1'b1;
    end else begin
      cr_ff <= nxt_cr;
    end
  end

  assign core_busy          = (cr_ff.st == SFE_RUN);
  assign busy_in_cycle_flag = core_busy;
  assign write_latch_flag   = cr_ff.wlf;
  assign arr_op_start       = cr_ff.op_start;
  assign arr_op             = cr_ff.op;
  assign arr_addr           = cr_ff.addr;
  assign arr_rd_data        = cr_ff.rd_data;
  assign arr_rd_valid       = cr_ff.rd_valid;

  // ---------------- checks ----------------
  a_start_needs_latch: assert property (@(posedge core_clk) disable iff (rst)
    $rose(arr_op_start) |-> $past(cr_ff.wlf))
    else $error("operation started without write latch");

  a_start_sets_busy: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start |-> busy_in_cycle_flag && !$past(busy_in_cycle_flag))
    else $error("start did not begin a busy cycle");

  a_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
    busy_in_cycle_flag && cr_ff.timer != '0 |=> busy_in_cycle_flag)
    else $error("busy dropped before the timer ran out");

  a_end_clears: assert property (@(posedge core_clk) disable iff (rst)
    $fell(busy_in_cycle_flag) |-> !write_latch_flag ##1 !arr_op_start)
    else $error("cycle end left write latch set");

  a_chip_guard: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_CHIP |-> $past(block_protection_level) == BP_NONE)
    else $error("chip erase ran with protection set");

  a_sector_align: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_SECTOR |-> arr_addr[SECTOR_LSB-1:0] == '0)
    else $error("sector erase address not aligned");

  a_page_timer: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_PAGE |-> cr_ff.timer == PAGE_CYC - 32'h0000_0001)
    else $error("page program timer loaded wrongly");

  a_prot_guard: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_BLOCK |->
      !is_protected($past(block_protection_level), arr_addr | 24'h00_FFFF))
    else $error("block erase ran on a protected block");

  a_enh_exit: assert property (@(posedge spi_sclk) disable iff (rst)
    fenh && nxt_cnt == CNT_OPCODE && byte_in == RESET_BYTE && !enh_enter |=> !lk_ff.enh)
    else $error("all-ones byte did not leave enhanced mode");

  a_start_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start |=> !arr_op_start)
    else $error("start pulse lasted more than one cycle");

  a_latch_clear_end: assert property (@(posedge core_clk) disable iff (rst)
    $fell(write_latch_flag) |-> $past(busy_in_cycle_flag) || $past(rst))
    else $error("write latch cleared outside a cycle end");

  a_latch_set_idle: assert property (@(posedge core_clk) disable iff (rst)
    $rose(write_latch_flag) |-> !busy_in_cycle_flag)
    else $error("write latch set during a cycle");

  a_half_align: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_HALF |-> arr_addr[HALF_LSB-1:0] == '0)
    else $error("32K erase address not aligned");

  a_block_align: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_BLOCK |-> arr_addr[BLOCK_LSB-1:0] == '0)
    else $error("64K erase address not aligned");

  a_page_align: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_PAGE |-> arr_addr[PAGE_LSB-1:0] == '0)
    else $error("page program address not aligned");

  a_chip_addr: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_CHIP |-> arr_addr == '0)
    else $error("chip erase address not zero");

  a_sector_prot: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_SECTOR |->
      !is_protected($past(block_protection_level), arr_addr | 24'h00_0FFF))
    else $error("sector erase ran on a protected block");

  a_page_prot: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_PAGE |->
      !is_protected($past(block_protection_level), arr_addr | 24'h00_00FF))
    else $error("page program ran on a protected block");

  a_erase_shape: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op inside {SFE_OP_SECTOR, SFE_OP_HALF, SFE_OP_BLOCK} |->
      $past(lk_ff.last_cnt) == CNT_ADDR)
    else $error("erase started on a frame of the wrong length");

  a_page_shape: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_PAGE |-> $past(lk_ff.last_cnt) == CNT_DATA_END)
    else $error("page program started off a byte boundary");

  a_sector_timer: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start && arr_op == SFE_OP_SECTOR |-> cr_ff.timer == SECTOR_CYC - 32'h0000_0001)
    else $error("sector erase timer loaded wrongly");

  a_enh_frame_skip: assert property (@(posedge core_clk) disable iff (rst)
    arr_op_start |-> !$past(lk_ff.frame_enh))
    else $error("enhanced-mode frame started an operation");
endmodule

// ===== tb/serial_flash_erase_program_test.sv
// self-checking bench for the erase and program sequencer
`timescale 1ns/100ps
module serial_flash_erase_program_test;
  import sfe_pkg::*;
  // short self-timed cycles keep the run small
  localparam int SE_NS = 100;
  localparam int HB_NS = 150;
  localparam int BK_NS = 200;
  localparam int CE_NS = 250;
  localparam int PP_NS = 2800;
  logic              core_clk;
  logic              rst;
  logic              spi_sclk;
  logic              spi_cs_n;
  logic              spi_si;
  logic              enh_enter;
  logic              enh_exit;
  logic [BP_W-1:0]   block_protection_level;
  logic              write_latch_flag;
  logic              busy_in_cycle_flag;
  logic              enh_mode_active;
  logic              arr_op_start;
  sfe_op_t           arr_op;
  logic [ADDR_W-1:0] arr_addr;
  logic [7:0]        arr_rd_idx;
  logic [7:0]        arr_rd_data;
  logic              arr_rd_valid;
  int                mismatches;
  int                samples_checked;
  int                cycles;
  bit                latch_exp;
  logic [7:0]        page_exp [PAGE_BYTES];
  logic              page_vld [PAGE_BYTES];
  sfe_op_t           op_r;

  sfe_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

  sfe_sequencer #(
    .SECTOR_ERASE_TIME_NS(SE_NS), .HALF_BLOCK_ERASE_TIME_NS(HB_NS),
    .BLOCK_ERASE_TIME_NS(BK_NS), .WHOLE_ERASE_TIME_NS(CE_NS), .PAGE_PROGRAM_TIME_NS(PP_NS)
  ) dut (
    .core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .enh_enter(enh_enter), .enh_exit(enh_exit),
    .block_protection_level(block_protection_level), .write_latch_flag(write_latch_flag),
    .busy_in_cycle_flag(busy_in_cycle_flag), .enh_mode_active(enh_mode_active),
    .arr_op_start(arr_op_start), .arr_op(arr_op), .arr_addr(arr_addr),
    .arr_rd_idx(arr_rd_idx), .arr_rd_data(arr_rd_data), .arr_rd_valid(arr_rd_valid)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic int cyc_of(sfe_op_t op);
    case (op)
      SFE_OP_SECTOR: return (SE_NS + 9) / 10;
      SFE_OP_HALF:   return (HB_NS + 9) / 10;
      SFE_OP_BLOCK:  return (BK_NS + 9) / 10;
      SFE_OP_CHIP:   return (CE_NS + 9) / 10;
      default:       return (PP_NS + 9) / 10;
    endcase
  endfunction

  function automatic logic [7:0] opc_of(sfe_op_t op);
    case (op)
      SFE_OP_SECTOR: return OPC_SECTOR;
      SFE_OP_HALF:   return OPC_HALF;
      SFE_OP_BLOCK:  return OPC_BLOCK;
      SFE_OP_CHIP:   return OPC_CHIP;
      default:       return OPC_PAGE;
    endcase
  endfunction

  function automatic logic [23:0] base_of(sfe_op_t op, logic [23:0] a);
    case (op)
      SFE_OP_SECTOR: return a & 24'hff_f000;
      SFE_OP_HALF:   return a & 24'hff_8000;
      SFE_OP_BLOCK:  return a & 24'hff_0000;
      SFE_OP_PAGE:   return a & 24'hff_ff00;
      default:       return 24'h00_0000;
    endcase
  endfunction

  function automatic bit prot_of(sfe_op_t op, logic [3:0] bp, logic [23:0] a);
    if (op == SFE_OP_CHIP) return bp != BP_NONE;
    if (bp == BP_NONE) return 1'b0;
    if (bp > 4'h8) return 1'b1;
    return 9'(a[23:16]) >= BLOCK_COUNT - (9'h001 << (bp - 4'h1));
  endfunction

  task automatic issue(input sfe_op_t op, input logic [23:0] a, input logic [3:0] bp,
                       input bit unlock, input int nb, input int extra);
    logic [7:0] b;
    bit         ok;
    int         n;
    @(posedge core_clk) block_protection_level <= bp;
    if (unlock) begin
      host.q.push_back(OPC_UNLOCK);
      host.frame(8);
      wait_cyc(6);
      latch_exp = 1'b1;
      check("write_latch_flag", write_latch_flag, 1);
    end
    ok = latch_exp && extra == 0 && !prot_of(op, bp, a);
    host.q.push_back(opc_of(op));
    if (op != SFE_OP_CHIP) begin
      host.q.push_back(a[23:16]);
      host.q.push_back(a[15:8]);
      host.q.push_back(a[7:0]);
    end
    if (ok) page_vld = '{default: 1'b0};
    for (int k = 0; k < nb; k++) begin
      b = 8'($urandom);
      host.q.push_back(b);
      page_exp[8'(a[7:0] + k)] = b;
      page_vld[8'(a[7:0] + k)] = ok;
    end
    host.frame(8 * host.q.size() + extra);
    n = 0;
    while (arr_op_start !== 1'b1 && n < 10) begin
      wait_cyc(1);
      n++;
    end
    check("arr_op_start", arr_op_start, ok);
    if (ok) begin
      check("arr_op", arr_op, op);
      check("arr_addr", arr_addr, base_of(op, a));
      n = 0;
      while (busy_in_cycle_flag === 1'b1 && n < 400) begin
        @(posedge core_clk) arr_rd_idx <= 8'(n);
        #1;
        if (op == SFE_OP_PAGE && n >= 1 && n <= PAGE_BYTES) begin
          check("arr_rd_valid", arr_rd_valid, page_vld[n-1]);
          if (page_vld[n-1]) check("arr_rd_data", arr_rd_data, page_exp[n-1]);
        end
        n++;
      end
      latch_exp = 1'b0;
      check("busy cycles", n, cyc_of(op));
    end
    check("busy_in_cycle_flag", busy_in_cycle_flag, 0);
    check("write_latch_flag", write_latch_flag, latch_exp);
    wait_cyc(6);
  endtask

  task automatic do_reset(input int n);
    @(posedge core_clk) rst <= 1'b1;
    repeat (n) @(posedge core_clk);
    rst <= 1'b0;
    latch_exp = 1'b0;
    wait_cyc(4);
  endtask

  // enter is held across a short dummy frame so the link clock samples it
  task automatic enter_enh();
    @(posedge core_clk) enh_enter <= 1'b1;
    host.q.push_back(8'h00);
    host.frame(8);
    @(posedge core_clk) enh_enter <= 1'b0;
    wait_cyc(6);
    check("enh_mode_active", enh_mode_active, 1);
  endtask

  initial begin
    rst = 1'b1;
    enh_enter = 1'b0;
    enh_exit = 1'b0;
    block_protection_level = 4'h0;
    arr_rd_idx = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    latch_exp = 1'b0;
    void'($urandom(32'ha430_72e3));
    do_reset(11);
    check("reset flags", {write_latch_flag, busy_in_cycle_flag, enh_mode_active}, 0);
    check("reset arr_op", arr_op, SFE_OP_NONE);
    enter_enh();
    host.q.push_back(OPC_UNLOCK);
    host.frame(8);
    wait_cyc(6);
    check("write_latch_flag", write_latch_flag, 0);
    host.q.push_back(RESET_BYTE);
    host.frame(8);
    wait_cyc(6);
    check("enh_mode_active", enh_mode_active, 0);
    // the read path may also drop enhanced mode; held across a frame so sclk samples it
    enter_enh();
    @(posedge core_clk) enh_exit <= 1'b1;
    host.q.push_back(8'h00);
    host.frame(8);
    @(posedge core_clk) enh_exit <= 1'b0;
    wait_cyc(6);
    check("enh_mode_active", enh_mode_active, 0);
    check("write_latch_flag", write_latch_flag, 0);
    issue(SFE_OP_SECTOR, 24'h12_3456, 4'h0, 1'b0, 0, 0);
    issue(SFE_OP_SECTOR, 24'hff_ffff, 4'h1, 1'b1, 0, 0);
    issue(SFE_OP_BLOCK, 24'hfe_1234, 4'h1, 1'b0, 0, 0);
    issue(SFE_OP_CHIP, 24'h00_0000, 4'h1, 1'b1, 0, 0);
    issue(SFE_OP_CHIP, 24'h00_0000, 4'h0, 1'b0, 0, 0);
    issue(SFE_OP_HALF, 24'h00_7fff, 4'h0, 1'b1, 0, -1);
    issue(SFE_OP_HALF, 24'h00_7fff, 4'h0, 1'b0, 0, 0);
    issue(SFE_OP_PAGE, 24'h12_34f0, 4'h0, 1'b1, 3, -3);
    issue(SFE_OP_PAGE, 24'h12_34f0, 4'h0, 1'b0, 258, 0);
    for (int i = 0; i < 14; i++) begin
      op_r = sfe_op_t'(1 + $urandom_range(4));
      issue(op_r, 24'($urandom), ($urandom_range(3) == 0) ? 4'($urandom_range(9)) : 4'h0,
            $urandom_range(4) != 0, (op_r == SFE_OP_PAGE) ? 1 + $urandom_range(15) : 0,
            ($urandom_range(5) == 0) ? -1 - int'($urandom_range(6)) : 0);
    end
    host.q.push_back(OPC_UNLOCK);
    host.frame(8);
    wait_cyc(6);
    enter_enh();
    do_reset(2);
    check("reset mid-op", {write_latch_flag, enh_mode_active}, 0);
    issue(SFE_OP_SECTOR, 24'h00_1fff, 4'h0, 1'b1, 0, 0);
    complete_run();
  end
endmodule

// ===== tb/sfe_host.sv
// serial host model: frames bytes onto the single-line link, clock idle between frames
`timescale 1ns/100ps
module sfe_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si
);
  logic [7:0] q[$];

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // sends nbits from q, msb first, then deselects; q is emptied
  task automatic frame(input int nbits);
    #3 spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_si = q[i/8][7-(i%8)];
      #24 spi_sclk = 1'b1;
      #24 spi_sclk = 1'b0;
    end
    // a released data line shows the inverse so a stale bit is never trusted
    spi_si = ~spi_si;
    #10 spi_cs_n = 1'b1;
    q.delete();
  endtask
endmodule
